//--- design/serial_bus_stop_ctrl.sv
// stop request, start gating and serial interrupt flag of the two-wire bus interface
`timescale 1ns/10ps
`default_nettype none
`include "serial_bus_map.svh"

// Overview of operation
// (R1) With start request clear, no start or repeated start is made.
// (R2) Stop request set as master sends a stop condition onto the bus.
// (R3) A stop seen on the bus clears the stop request bit.
// (R4) Stop request in slave mode drives no stop onto the bus.
// (R5) Slave stop request acts as a received stop, entering not-addressed receiver.
// (R6) Both requests set as master: stop first, then start.
// (R7) Both requests set as slave: internal stop, no stop driven; a start is still driven once the bus is free.
// (R8) With stop request clear, no stop condition is made.
// (R9) Entering any status state except no-information sets the interrupt flag.
// (R10) Entering the no-information state never sets the interrupt flag.
// (R11) While the flag is set, clock is held low once low, released while high.
// (R12) Firmware alone clears the interrupt flag; hardware never clears it.
// (R13) Flag clear: no interrupt request and clock released, no stretching.
// (R14) Interrupt reaches the CPU only with flag set and enable bit set.
module serial_bus_stop_ctrl
  import serial_bus_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic       link_clk,
  input  wire logic       ctrl_wr,
  input  wire logic [7:0] ctrl_wdata,
  output logic      [7:0] ctrl_rdata,
  input  wire logic       start_clear,
  input  wire logic       is_master,
  input  wire logic       state_entry,
  input  wire logic [7:0] state_code,
  input  wire logic       bus_irq_enable,
  output logic            bus_irq,
  output logic            not_addressed_entry,
  output logic            stop_seen,
  output logic            start_sent,
  output logic      [2:0] rate_sel,
  output logic            ack_enable,
  output logic            iface_enable,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe
);

  // ****************************************************************
  // core domain: control register
  // ****************************************************************
  logic [7:0]  ctrl_reg;
  logic        flag_reg;
  logic        stop_req_reg;
  logic        start_req_reg;
  logic        recover_reg;
  logic [1:0]  up_seen_reg;
  logic        stop_evt;
  logic        start_evt;
  logic        wr_stop_set;
  logic        wr_flag_clr;
  logic        flag_set;
  logic        slave_recover;

  cross_if #(.WIDTH(`DOWN_WIDTH)) down_if ();
  cross_if #(.WIDTH(`UP_WIDTH))   up_if ();
  cross_if #(.WIDTH(`PIN_WIDTH))  pin_if ();

  assign wr_stop_set   = ctrl_wr && ctrl_wdata[`CTRL_STOP_BIT];
  assign wr_flag_clr   = ctrl_wr && !ctrl_wdata[`CTRL_FLAG_BIT];
  assign flag_set      = state_entry && (state_code != `NO_INFO_CODE);  // [R9] [R10]
  // slave recovery needs no bus activity, so it completes inside the core domain
  assign slave_recover = stop_req_reg && !is_master;  // [R4] [R5] [R7]

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_reg <= `CTRL_RESET;
    else if (clk_en && ctrl_wr)
      ctrl_reg <= ctrl_wdata;
  end
  // set wins over the firmware clear so no state entry is lost
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      flag_reg <= 1'b0;
    else if (clk_en)
    begin
      if (flag_set)
        flag_reg <= 1'b1;  // [R9]
      else if (wr_flag_clr)
        flag_reg <= 1'b0;  // [R12]
    end
  end
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      stop_req_reg <= 1'b0;
    else if (clk_en)
    begin
      if (wr_stop_set)
        stop_req_reg <= 1'b1;
      else if (stop_evt || slave_recover)
        stop_req_reg <= 1'b0;  // [R3] [R5]
    end
  end
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      start_req_reg <= 1'b0;
    else if (clk_en)
    begin
      if (ctrl_wr && ctrl_wdata[`CTRL_START_BIT])
        start_req_reg <= 1'b1;
      else if (start_clear || (ctrl_wr && !ctrl_wdata[`CTRL_START_BIT]))
        start_req_reg <= 1'b0;
    end
  end
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      recover_reg <= 1'b0;
    else if (clk_en)
      recover_reg <= slave_recover && !wr_stop_set;  // [R5]
  end

  // ****************************************************************
  // core domain: events from the link
  // ****************************************************************
  assign stop_evt  = up_if.sync_bits[`UP_STOP] != up_seen_reg[`UP_STOP];
  assign start_evt = up_if.sync_bits[`UP_START] != up_seen_reg[`UP_START];
  // edge memory and pulses move together so no toggle is reported twice
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      up_seen_reg <= '0;
      stop_seen   <= 1'b0;
      start_sent  <= 1'b0;
    end
    else if (clk_en)
    begin
      up_seen_reg <= up_if.sync_bits;
      stop_seen   <= stop_evt;
      start_sent  <= start_evt;
    end
  end

  assign not_addressed_entry = recover_reg;
  assign bus_irq      = flag_reg && bus_irq_enable;  // [R13] [R14]
  assign rate_sel     = {ctrl_reg[`CTRL_RATE2_BIT], ctrl_reg[`CTRL_RATE1_BIT],
                         ctrl_reg[`CTRL_RATE0_BIT]};
  assign ack_enable   = ctrl_reg[`CTRL_ACK_BIT];
  assign iface_enable = ctrl_reg[`CTRL_ENABLE_BIT];

  always_comb
  begin
    ctrl_rdata = ctrl_reg;
    ctrl_rdata[`CTRL_START_BIT] = start_req_reg;
    ctrl_rdata[`CTRL_STOP_BIT]  = stop_req_reg;
    ctrl_rdata[`CTRL_FLAG_BIT]  = flag_reg;
  end

  // ****************************************************************
  // crossings
  // ****************************************************************
  // only master stop requests reach the link
  assign down_if.async_bits[`DOWN_CE]    = clk_en;
  assign down_if.async_bits[`DOWN_FLAG]  = flag_reg;
  assign down_if.async_bits[`DOWN_STOP]  = stop_req_reg && is_master;  // [R4] [R7]
  assign down_if.async_bits[`DOWN_START] = start_req_reg;
  assign pin_if.async_bits[`PIN_SCL]     = scl_in;
  assign pin_if.async_bits[`PIN_SDA]     = sda_in;

  bit_sync #(.WIDTH(`DOWN_WIDTH)) down_sync (
    .clk     (link_clk),
    .reset_n (reset_n),
    .port_if (down_if.syncer)
  );
  bit_sync #(.WIDTH(`PIN_WIDTH)) pin_sync (
    .clk     (link_clk),
    .reset_n (reset_n),
    .port_if (pin_if.syncer)
  );
  bit_sync #(.WIDTH(`UP_WIDTH)) up_sync (
    .clk     (core_clk),
    .reset_n (reset_n),
    .port_if (up_if.syncer)
  );

  // ****************************************************************
  // link domain: line monitor
  // ****************************************************************
  wire logic   ce_s     = down_if.sync_bits[`DOWN_CE];
  wire logic   flag_s   = down_if.sync_bits[`DOWN_FLAG];
  wire logic   stop_go  = down_if.sync_bits[`DOWN_STOP];
  wire logic   start_go = down_if.sync_bits[`DOWN_START];
  wire logic   scl_s    = pin_if.sync_bits[`PIN_SCL];
  wire logic   sda_s    = pin_if.sync_bits[`PIN_SDA];
  logic        sda_prev_reg;
  logic        busy_reg;
  logic        stretch_reg;
  logic [1:0]  up_tgl_reg;
  logic        line_stop;
  logic        line_start;
  link_state_t state_reg;
  link_state_t state_next;

  assign line_stop  = scl_s && sda_s && !sda_prev_reg;
  assign line_start = scl_s && !sda_s && sda_prev_reg;
  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sda_prev_reg <= 1'b1;
      busy_reg     <= 1'b0;
    end
    else if (ce_s)
    begin
      sda_prev_reg <= sda_s;
      if (line_start)
        busy_reg <= 1'b1;
      else if (line_stop)
        busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
      up_tgl_reg <= '0;
    else if (ce_s)
    begin
      if (line_stop)
        up_tgl_reg[`UP_STOP] <= !up_tgl_reg[`UP_STOP];  // [R3]
      if (state_reg == L_START_B)
        up_tgl_reg[`UP_START] <= !up_tgl_reg[`UP_START];
    end
  end
  assign up_if.async_bits = up_tgl_reg;
  // the synchronised flag lags by two link edges; a stretch can start that late
  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
      stretch_reg <= 1'b0;
    else if (ce_s)
      stretch_reg <= flag_s && (stretch_reg || !scl_s);  // [R11] [R13]
  end

  // ****************************************************************
  // link domain: condition sequencer
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      L_IDLE:
      begin
        if (stop_go)
          state_next = L_STOP_A;  // [R2] [R6] [R8]
        else if (start_go && !busy_reg)
          state_next = L_START_A;  // [R1]
      end
      L_STOP_A:     state_next = L_STOP_B;
      L_STOP_B:     state_next = L_STOP_C;
      L_STOP_C:     state_next = L_WAIT_STOP;
      L_WAIT_STOP:  state_next = stop_go ? L_WAIT_STOP : L_IDLE;
      L_START_A:    state_next = (scl_s && sda_s) ? L_START_B : L_START_A;
      L_START_B:    state_next = L_WAIT_START;
      L_WAIT_START: state_next = (start_go || stop_go) ? L_WAIT_START : L_IDLE;
      default:      state_next = L_IDLE;
    endcase
    if (state_reg == L_WAIT_START && stop_go)
      state_next = L_STOP_A;
  end
  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= L_IDLE;
    else if (ce_s)
      state_reg <= state_next;
  end

  // open-drain: both pins only ever pull low
  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (ce_s)
    begin
      scl_oe <= (state_next == L_STOP_A) || (state_next == L_WAIT_START) ||
                (flag_s && (stretch_reg || !scl_s));  // [R11] [R13]
      sda_oe <= (state_next == L_STOP_A) || (state_next == L_STOP_B) ||
                (state_next == L_START_B) || (state_next == L_WAIT_START);
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_flag_set;
    @(posedge core_clk) disable iff (!reset_n)
    clk_en && state_entry && (state_code != `NO_INFO_CODE) |=> flag_reg && ctrl_rdata[3];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on state entry");  // [R9]
  property p_no_info;
    @(posedge core_clk) disable iff (!reset_n)
    state_entry && (state_code == `NO_INFO_CODE) && !flag_reg |=> !flag_reg;
  endproperty
  a_no_info: assert property (p_no_info) else $error("flag set by no-info state");  // [R10]
  property p_flag_kept;
    @(posedge core_clk) disable iff (!reset_n)
    flag_reg && !(clk_en && wr_flag_clr) |=> flag_reg;
  endproperty
  a_flag_kept: assert property (p_flag_kept) else $error("flag cleared by hardware");  // [R12]
  property p_irq_gate;
    @(posedge core_clk) disable iff (!reset_n)
    bus_irq == (flag_reg && bus_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt without flag");  // [R14]
  property p_stop_clear;
    @(posedge core_clk) disable iff (!reset_n)
    clk_en && stop_evt && !wr_stop_set |=> !stop_req_reg && stop_seen;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop request kept");  // [R3]
  property p_recover;
    @(posedge core_clk) disable iff (!reset_n)
    clk_en && stop_req_reg && !is_master && !wr_stop_set |=> not_addressed_entry && !stop_req_reg;
  endproperty
  a_recover: assert property (p_recover) else $error("slave recovery missing");  // [R5]
  property p_stop_go;
    @(posedge link_clk) disable iff (!reset_n)
    ce_s && state_reg == L_IDLE && stop_go |=> state_reg == L_STOP_A ##1 state_reg == L_STOP_B;
  endproperty
  a_stop_go: assert property (p_stop_go) else $error("stop not started");  // [R2] [R6]
  property p_no_stop;
    @(posedge link_clk) disable iff (!reset_n)
    state_reg == L_IDLE && !stop_go |=> state_reg != L_STOP_A;
  endproperty
  a_no_stop: assert property (p_no_stop) else $error("stop without request");  // [R8] [R4]
  property p_no_start;
    @(posedge link_clk) disable iff (!reset_n)
    state_reg == L_IDLE && !start_go |=> state_reg != L_START_A;
  endproperty
  a_no_start: assert property (p_no_start) else $error("start without request");  // [R1]
  property p_stretch;
    @(posedge link_clk) disable iff (!reset_n)
    stretch_reg |-> scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock not held");  // [R11]
  property p_release;
    @(posedge link_clk) disable iff (!reset_n)
    ce_s && !flag_s |=> !stretch_reg;
  endproperty
  a_release: assert property (p_release) else $error("clock stretched with flag clear");  // [R13]
  c_stop_sent:  cover property (@(posedge link_clk) state_reg == L_STOP_C);
  c_start_sent: cover property (@(posedge link_clk) state_reg == L_START_B);
  c_recover:    cover property (@(posedge core_clk) not_addressed_entry);
  c_stretch:    cover property (@(posedge link_clk) stretch_reg && !scl_s);
endmodule

`default_nettype wire

//--- shared/serial_bus_map.svh
// bit positions, reset values and codes of the serial bus control register
`ifndef SERIAL_BUS_MAP_SVH
`define SERIAL_BUS_MAP_SVH

// ****************************************************************
// control register layout
// ****************************************************************
`define CTRL_RESET      8'h00
`define CTRL_RATE2_BIT  7
`define CTRL_ENABLE_BIT 6
`define CTRL_START_BIT  5
`define CTRL_STOP_BIT   4
`define CTRL_FLAG_BIT   3
`define CTRL_ACK_BIT    2
`define CTRL_RATE1_BIT  1
`define CTRL_RATE0_BIT  0

// ****************************************************************
// status codes and crossing widths
// ****************************************************************
`define NO_INFO_CODE    8'hF8
`define DOWN_WIDTH      4
`define DOWN_CE         0
`define DOWN_FLAG       1
`define DOWN_STOP       2
`define DOWN_START      3
`define UP_WIDTH        2
`define UP_STOP         0
`define UP_START        1
`define PIN_WIDTH       2
`define PIN_SCL         0
`define PIN_SDA         1

`endif

//--- shared/serial_bus_pkg.sv
// types of the serial bus stop and interrupt control
package serial_bus_pkg;

  // ****************************************************************
  // link sequencer states
  // ****************************************************************
  typedef enum logic [7:0] {
    L_IDLE       = 8'h01,
    L_STOP_A     = 8'h02,
    L_STOP_B     = 8'h04,
    L_STOP_C     = 8'h08,
    L_WAIT_STOP  = 8'h10,
    L_START_A    = 8'h20,
    L_START_B    = 8'h40,
    L_WAIT_START = 8'h80
  } link_state_t;

endpackage

//--- shared/cross_if.sv
// carrier of a group of bits that enters a clock domain
`timescale 1ns/10ps
`default_nettype none

interface cross_if #(parameter int WIDTH = 1);
  logic [WIDTH-1:0] async_bits;
  logic [WIDTH-1:0] sync_bits;

  modport sender (output async_bits, input sync_bits);
  modport syncer (input async_bits, output sync_bits);
endinterface

`default_nettype wire

//--- design/bit_sync.sv
// two flip-flop synchroniser for a group of independent level bits
`timescale 1ns/10ps
`default_nettype none

module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic clk,
  input  wire logic reset_n,
  cross_if.syncer   port_if
);
  // ****************************************************************
  // two stages
  // ****************************************************************
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] stable_reg;

  if (WIDTH < 1)
  begin : g_width_check
    $error("bit_sync needs at least one bit");
  end

  // each bit must be an independent level or a toggle; words do not cross here
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_reg   <= '0;
      stable_reg <= '0;
    end
    else
    begin
      meta_reg   <= port_if.async_bits;
      stable_reg <= meta_reg;
    end
  end

  assign port_if.sync_bits = stable_reg;
endmodule

`default_nettype wire

//--- verification/bus_partner.sv
// two-wire bus peer: pull-up wiring, clock stretching and condition counting
`timescale 1ns/10ps
`default_nettype none

module bus_partner (
  input  wire logic scl_oe,
  input  wire logic scl_out,
  input  wire logic sda_oe,
  input  wire logic sda_out,
  input  wire logic hold_low,
  output logic      scl,
  output logic      sda,
  output int        n_stop,
  output int        n_start,
  output logic      last_start
);
  // ****************************************************************
  // wired lines
  // ****************************************************************
  // pull-ups: a released line reads high, any driver pulling low wins
  assign scl = !((scl_oe && !scl_out) || hold_low);
  assign sda = !(sda_oe && !sda_out);

  // ****************************************************************
  // condition monitor
  // ****************************************************************
  initial
  begin
    n_stop = 0;
    n_start = 0;
    last_start = 1'b0;
  end

  // look 1 ns after a data edge so that a data and clock edge in the same
  // step (clock falling together with data) is not mistaken for a condition
  always @(sda)
  begin
    #1;
    if ($time > 100 && scl === 1'b1 && sda === 1'b1)
    begin
      n_stop = n_stop + 1;
      last_start = 1'b0;
    end
    else if ($time > 100 && scl === 1'b1 && sda === 1'b0)
    begin
      n_start = n_start + 1;
      last_start = 1'b1;
    end
  end
endmodule

`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench of the stop request and serial interrupt control
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  typedef struct packed {
    logic [7:0] code;
    logic       en;
    logic       flag;
    logic       irq;
  } row_t;

  logic       core_clk, reset_n, link_clk, ctrl_wr, start_clear, is_master;
  logic       state_entry, bus_irq_enable, hold_low, bus_irq, not_addressed_entry;
  logic       stop_seen, start_sent, ack_enable, iface_enable, scl, sda;
  logic       scl_out, scl_oe, sda_out, sda_oe, last_start, got, clk_en;
  logic [7:0] ctrl_wdata, ctrl_rdata, state_code;
  logic [2:0] rate_sel;
  int         n_stop, n_start, n_mismatch, check_count, pulses;
  row_t       rows [4] = '{'{8'h08, 1'b1, 1'b1, 1'b1}, '{8'h10, 1'b0, 1'b1, 1'b0},
                           '{8'hF8, 1'b1, 1'b0, 1'b0}, '{8'hC8, 1'b1, 1'b1, 1'b1}};

  serial_bus_stop_ctrl dut (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .link_clk(link_clk),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
    .start_clear(start_clear), .is_master(is_master), .state_entry(state_entry),
    .state_code(state_code), .bus_irq_enable(bus_irq_enable), .bus_irq(bus_irq),
    .not_addressed_entry(not_addressed_entry), .stop_seen(stop_seen),
    .start_sent(start_sent), .rate_sel(rate_sel), .ack_enable(ack_enable),
    .iface_enable(iface_enable), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe)
  );

  bus_partner peer (
    .scl_oe(scl_oe), .scl_out(scl_out), .sda_oe(sda_oe), .sda_out(sda_out),
    .hold_low(hold_low), .scl(scl), .sda(sda), .n_stop(n_stop), .n_start(n_start),
    .last_start(last_start)
  );

  // ****************************************************************
  // clocks and watchdog
  // ****************************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // phase offset keeps link edges away from core edges
  initial
  begin
    link_clk = 1'b0;
    #17;
    forever #62.5 link_clk = ~link_clk;
  end

  initial
  begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] d);
    @(negedge core_clk);
    ctrl_wr = 1'b1;
    ctrl_wdata = d;
    @(negedge core_clk);
    ctrl_wr = 1'b0;
  endtask

  task automatic entry(input logic [7:0] code);
    @(negedge core_clk);
    state_entry = 1'b1;
    state_code = code;
    @(negedge core_clk);
    state_entry = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic link_wait();
    repeat (12) @(posedge link_clk);
    @(negedge core_clk);
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    n_mismatch = 0;
    check_count = 0;
    reset_n = 1'b0;
    {ctrl_wr, start_clear, is_master, state_entry, bus_irq_enable, hold_low} = '0;
    ctrl_wdata = 8'h00;
    clk_en = 1'b1;
    state_code = 8'hF8;
    repeat (20) @(negedge core_clk);
    check("reset rdata", ctrl_rdata, 8'h00);
    check("reset oe", {6'h00, scl_oe, sda_oe}, 8'h00);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);

    // state entries: flag and irq gating per row
    foreach (rows[i])
    begin
      bus_irq_enable = rows[i].en;
      wr(8'h00);
      entry(rows[i].code);
      check("flag", {7'h00, ctrl_rdata[3]}, {7'h00, rows[i].flag});
      check("irq", {7'h00, bus_irq}, {7'h00, rows[i].irq});
    end

    // writing one to the flag leaves it set; only a written zero clears it
    wr(8'h08);
    repeat (50) @(negedge core_clk);
    check("flag kept", {7'h00, ctrl_rdata[3]}, 8'h01);
    link_wait();
    check("scl high no drive", {7'h00, scl_oe}, 8'h00);
    hold_low = 1'b1;
    link_wait();
    hold_low = 1'b0;
    link_wait();
    check("scl stretched", {6'h00, scl_oe, scl}, 8'h02);
    wr(8'h00);
    link_wait();
    check("scl released", {6'h00, scl_oe, scl}, 8'h01);
    check("irq off", {7'h00, bus_irq}, 8'h00);

    // slave recovery: internal stop only
    wr(8'h10);
    pulses = 0;
    repeat (10)
    begin
      @(negedge core_clk);
      pulses += int'(not_addressed_entry);
    end
    check("not addressed pulses", 8'(pulses), 8'h01);
    check("slave stop bit", {7'h00, ctrl_rdata[4]}, 8'h00);
    link_wait();
    check("slave bus stops", 8'(n_stop), 8'h00);

    // master stop
    is_master = 1'b1;
    wr(8'h10);
    got = 1'b0;
    for (int i = 0; i < 300 && !got; i++)
    begin
      @(negedge core_clk);
      got = stop_seen;
    end
    check("stop seen", {7'h00, got}, 8'h01);
    check("bus stops", 8'(n_stop), 8'h01);
    check("stop bit cleared", {7'h00, ctrl_rdata[4]}, 8'h00);
    check("no start yet", 8'(n_start), 8'h00);

    // both requests as master: stop first, then start
    wr(8'h30);
    got = 1'b0;
    for (int i = 0; i < 300 && !got; i++)
    begin
      @(negedge core_clk);
      got = start_sent;
    end
    link_wait();
    check("start sent", {7'h00, got}, 8'h01);
    check("order", {5'h00, 2'(n_stop), last_start}, 8'h05);
    check("one start", 8'(n_start), 8'h01);
    start_clear = 1'b1;
    @(negedge core_clk);
    start_clear = 1'b0;
    @(negedge core_clk);
    check("start bit cleared", {7'h00, ctrl_rdata[5]}, 8'h00);

    // remaining control bits read back and reach their outputs
    wr(8'hC7);
    @(negedge core_clk);
    check("rdata", ctrl_rdata, 8'hC7);
    check("fields", {3'h0, iface_enable, ack_enable, rate_sel}, 8'h1F);

    // clock enable low: a write is ignored and the register holds
    clk_en = 1'b0;
    wr(8'h00);
    @(negedge core_clk);
    check("frozen rdata", ctrl_rdata, 8'hC7);
    clk_en = 1'b1;
    tally_and_finish();
  end
endmodule

`default_nettype wire
